// File: rtl/bpm_top.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "bpm_cfg.svh"

// What this block does
// - bit mode adds errored B1 bits, max 8
// - frame mode adds one per errored B1
// - B1 mismatch sets status bit 3, interrupt
// - line parity over line overhead and envelope
// - line parity checked against next frame's B2
// - B2 mismatch sets status bit 4, interrupt
// - B2 errors advance 32-bit four-byte counter
// - frame mode adds one per errored frame
// - bit mode adds errored B2 bits, max 24
module bpm_top #(
	parameter int CNT_W = 32,
	parameter int LANES = 3
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  reset_n_i,
	input  wire bpm_pkg::bpm_rx_byte_t rx_byte_i,
	input  wire logic [15:0]           avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic                       avs_waitrequest_o,
	output logic      [31:0]           avs_readdata_o,
	output logic                       int_n_o
);
	import bpm_pkg::*;

	if (CNT_W < 8 || CNT_W > 32 || LANES < 1 || LANES > 4) begin : g_bad
		$error("bpm_top: CNT_W must be 8 to 32 and LANES 1 to 4");
	end

	// reset release through two flops
	logic rst_meta_r;
	logic rst_sync_n_r;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r   <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r   <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	logic                  restart;
	logic                  b1_ok;
	logic                  b2_ok;
	logic [0:0][7:0]       b1_prev;
	logic [LANES-1:0][7:0] b2_prev;

	assign restart = rx_byte_i.vld & rx_byte_i.sof;

	// section parity covers every byte of the frame
	bpm_bip_acc #(
		.LANES(1)
	) u_b1_acc (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_sync_n_r),
		.restart_i(restart),
		.en_i     (rx_byte_i.vld),
		.lane_i   (2'h0),
		.data_i   (rx_byte_i.data),
		.prev_o   (b1_prev),
		.prev_ok_o(b1_ok)
	);

	// line parity per tributary, section overhead rows left out
	bpm_bip_acc #(
		.LANES(LANES)
	) u_b2_acc (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_sync_n_r),
		.restart_i(restart),
		.en_i     (rx_byte_i.vld & ~rx_byte_i.soh),
		.lane_i   (rx_byte_i.slot),
		.data_i   (rx_byte_i.data),
		.prev_o   (b2_prev),
		.prev_ok_o(b2_ok)
	);

	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] irqen_r, irqen_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic [7:0] stat_set, stat_clr;
	logic       b2_seen_r, b2_seen_nxt;
	logic [7:0] b2_sel;
	logic       slot_ok;
	logic [7:0] b1_diff, b2_diff;
	logic       b1_err, b2_err;
	logic [4:0] b1_add, b2_add;

	// compare the stored parity with the parity byte of the following frame
	always_comb begin
		b2_sel  = 8'h00;
		slot_ok = 1'b0;
		for (int i = 0; i < LANES; i++) begin
			if (rx_byte_i.slot == 2'(i)) begin
				b2_sel  = b2_prev[i];
				slot_ok = 1'b1;
			end
		end
		b1_diff = rx_byte_i.data ^ b1_prev[0];
		b2_diff = rx_byte_i.data ^ b2_sel;
		b1_err  = rx_byte_i.vld & rx_byte_i.b1 & b1_ok & (b1_diff != 8'h00);
		b2_err  = rx_byte_i.vld & rx_byte_i.b2 & b2_ok & slot_ok & (b2_diff != 8'h00);
	end

	// add amounts; frame mode counts a B2 frame only on its first bad byte
	always_comb begin
		b1_add = 5'h00;
		b2_add = 5'h00;
		if (b1_err) begin
			if (ctrl_r[`BPM_BIT_B1MODE]) begin
				b1_add = 5'h01;
			end else begin
				b1_add = {1'b0, bpm_ones8(b1_diff)};
			end
		end
		if (b2_err) begin
			if (ctrl_r[`BPM_BIT_B2MODE]) begin
				b2_add = b2_seen_r ? 5'h00 : 5'h01;
			end else begin
				b2_add = {1'b0, bpm_ones8(b2_diff)};
			end
		end
		b2_seen_nxt = restart ? 1'b0 : (b2_seen_r | b2_err);
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			b2_seen_r <= 1'b0;
		end else begin
			b2_seen_r <= b2_seen_nxt;
		end
	end

	logic [CNT_W-1:0] b1_cnt, b2_cnt;

	// bit mode adds at most 8 per parity byte, so a counter never sees more than 24 per frame with three lanes
	bpm_err_cnt #(
		.W(CNT_W)
	) u_b1_cnt (
		.clk_i  (ref_clk_i),
		.rst_n_i(rst_sync_n_r),
		.add_i  (b1_add),
		.cnt_o  (b1_cnt)
	);

	bpm_err_cnt #(
		.W(CNT_W)
	) u_b2_cnt (
		.clk_i  (ref_clk_i),
		.rst_n_i(rst_sync_n_r),
		.add_i  (b2_add),
		.cnt_o  (b2_cnt)
	);

	// bus side
	bpm_bus_st_t bus_st_r, bus_st_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] b1_hold_r, b1_hold_nxt;
	logic [31:0] b2_hold_r, b2_hold_nxt;
	logic        int_n_r, int_n_nxt;
	logic        req, prep, take;
	logic [13:0] reg_idx;

	assign reg_idx = avs_address_i[15:2];

	// index match, plain register
	function automatic logic at_idx(input logic [13:0] i);
		return reg_idx == i;
	endfunction

	// index match, one of the four bytes of a counter
	function automatic logic at_cnt(input logic [13:0] base);
		return reg_idx[13:2] == base[13:2];
	endfunction

	// byte 0 is the top byte and comes live; the others come from the snapshot
	function automatic logic [7:0] cnt_byte(input logic [31:0] live,
		input logic [31:0] hold);
		logic [7:0] b;
		case (reg_idx[1:0])
			2'h0: b = live[31:24];
			2'h1: b = hold[23:16];
			2'h2: b = hold[15:8];
			default: b = hold[7:0];
		endcase
		return b;
	endfunction

	// read mux; unmapped indices read zero
	function automatic logic [31:0] rd_word();
		logic [7:0] v;
		v = 8'h00;
		if (at_idx(`BPM_IDX_CTRL)) begin
			v = ctrl_r;
		end else if (at_idx(`BPM_IDX_IRQEN)) begin
			v = irqen_r;
		end else if (at_idx(`BPM_IDX_STAT)) begin
			v = stat_r;
		end else if (at_cnt(`BPM_IDX_B1CNT)) begin
			v = cnt_byte(32'(b1_cnt), b1_hold_r);
		end else if (at_cnt(`BPM_IDX_B2CNT)) begin
			v = cnt_byte(32'(b2_cnt), b2_hold_r);
		end
		return {24'h0, v};
	endfunction

	// two-cycle handshake: data latched on the first edge, taken on the second
	always_comb begin
		req         = avs_read_i | avs_write_i;
		prep        = req & (bus_st_r == BPM_IDLE);
		take        = req & (bus_st_r == BPM_ACK);
		bus_st_nxt  = prep ? BPM_ACK : BPM_IDLE;
		rdata_nxt   = rdata_r;
		b1_hold_nxt = b1_hold_r;
		b2_hold_nxt = b2_hold_r;
		ctrl_nxt    = ctrl_r;
		irqen_nxt   = irqen_r;
		stat_clr    = 8'h00;
		if (prep && avs_read_i) begin
			rdata_nxt = rd_word();
			// top-byte read freezes the rest, so the four bytes belong together
			if (at_idx(`BPM_IDX_B1CNT)) begin
				b1_hold_nxt = 32'(b1_cnt);
			end
			if (at_idx(`BPM_IDX_B2CNT)) begin
				b2_hold_nxt = 32'(b2_cnt);
			end
		end
		if (take && avs_write_i && avs_byteenable_i[0]) begin
			if (at_idx(`BPM_IDX_CTRL)) begin
				ctrl_nxt = avs_writedata_i[7:0] & `BPM_CTRL_WMASK;
			end else if (at_idx(`BPM_IDX_IRQEN)) begin
				irqen_nxt = avs_writedata_i[7:0] & `BPM_STAT_IMPL;
			end else if (at_idx(`BPM_IDX_STAT)) begin
				stat_clr = avs_writedata_i[7:0];
			end
		end
		// only bits that were shown are cleared, so a late event survives
		if (take && avs_read_i && at_idx(`BPM_IDX_STAT)) begin
			stat_clr = rdata_r[7:0];
		end
	end

	// sticky status, set beats clear; interrupt pin follows in the same edge
	always_comb begin
		stat_set = 8'h00;
		stat_set[`BPM_BIT_B1ERR] = b1_err;
		stat_set[`BPM_BIT_B2ERR] = b2_err;
		stat_nxt  = ((stat_r & ~stat_clr) | stat_set) & `BPM_STAT_IMPL;
		int_n_nxt = ~|(stat_nxt & irqen_nxt);
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			bus_st_r  <= BPM_IDLE;
			rdata_r   <= 32'h0000_0000;
			b1_hold_r <= 32'h0000_0000;
			b2_hold_r <= 32'h0000_0000;
			ctrl_r    <= `BPM_CTRL_RST;
			irqen_r   <= `BPM_IRQEN_RST;
			stat_r    <= 8'h00;
			int_n_r   <= 1'b1;
		end else begin
			bus_st_r  <= bus_st_nxt;
			rdata_r   <= rdata_nxt;
			b1_hold_r <= b1_hold_nxt;
			b2_hold_r <= b2_hold_nxt;
			ctrl_r    <= ctrl_nxt;
			irqen_r   <= irqen_nxt;
			stat_r    <= stat_nxt;
			int_n_r   <= int_n_nxt;
		end
	end

	// the idle code bit doubles as the wait flag
	assign avs_waitrequest_o = bus_st_r[0];
	assign avs_readdata_o    = rdata_r;
	assign int_n_o           = int_n_r;

	// shadow line parity of lane 0, only read by the checks below
	logic [7:0] chk_par_r, chk_par_nxt;

	always_comb begin
		chk_par_nxt = restart ? 8'h00 : chk_par_r;
		if (rx_byte_i.vld && !rx_byte_i.soh && rx_byte_i.slot == 2'h0) begin
			chk_par_nxt = chk_par_nxt ^ rx_byte_i.data;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			chk_par_r <= 8'h00;
		end else begin
			chk_par_r <= chk_par_nxt;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_sync_n_r);

	sequence s_b1_bad;
		b1_err && b1_cnt < CNT_W'(32'h0000_FF00);
	endsequence

	sequence s_b2_bad;
		b2_err && b2_cnt < CNT_W'(32'h0000_FF00);
	endsequence

	sequence s_stat_read;
		take && avs_read_i && at_idx(`BPM_IDX_STAT) && !b1_err && !b2_err;
	endsequence

	b1_bit_add_a: assert property (
		s_b1_bad ##0 !ctrl_r[`BPM_BIT_B1MODE] |=>
		b1_cnt == $past(b1_cnt) + CNT_W'(bpm_ones8($past(b1_diff))))
		else $error("b1 bit mode added wrong amount");

	b1_frame_add_a: assert property (
		s_b1_bad ##0 ctrl_r[`BPM_BIT_B1MODE] |=> b1_cnt == $past(b1_cnt) + 1'b1)
		else $error("b1 frame mode did not add one");

	b1_irq_a: assert property (
		b1_err && irqen_r[`BPM_BIT_B1ERR] |=> stat_r[`BPM_BIT_B1ERR] && !int_n_o)
		else $error("b1 error did not raise status and pin");

	line_parity_a: assert property (
		restart |=> b2_prev[0] == $past(chk_par_r))
		else $error("line parity differs from the frame's bytes");

	b2_compare_a: assert property (
		rx_byte_i.vld && rx_byte_i.b2 && b2_ok && rx_byte_i.slot == 2'h0 &&
		rx_byte_i.data != b2_prev[0] |-> b2_err)
		else $error("b2 mismatch not flagged");

	b2_irq_a: assert property (
		b2_err && irqen_r[`BPM_BIT_B2ERR] |=> stat_r[`BPM_BIT_B2ERR] && !int_n_o)
		else $error("b2 error did not raise status and pin");

	b2_count_a: assert property (
		s_b2_bad ##0 !b2_seen_r |=> b2_cnt > $past(b2_cnt))
		else $error("b2 counter did not advance");

	b2_frame_add_a: assert property (
		s_b2_bad ##0 ctrl_r[`BPM_BIT_B2MODE] |=>
		b2_cnt == $past(b2_cnt) + CNT_W'($past(b2_seen_r) ? 0 : 1))
		else $error("b2 frame mode added wrong amount");

	b2_bit_add_a: assert property (
		s_b2_bad ##0 !ctrl_r[`BPM_BIT_B2MODE] |=>
		b2_cnt == $past(b2_cnt) + CNT_W'(bpm_ones8($past(b2_diff))))
		else $error("b2 bit mode added wrong amount");

	stat_clear_a: assert property (
		s_stat_read |=> (stat_r & $past(rdata_r[7:0])) == 8'h00 &&
		int_n_o == !(|(stat_r & irqen_r)))
		else $error("status read did not clear or pin wrong");

	bus_answer_a: assert property (
		prep |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle after request");

endmodule

// File: rtl/bpm_cfg.svh
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define BPM_IDX_CTRL    14'h1103
`define BPM_IDX_IRQEN   14'h1107
`define BPM_IDX_STAT    14'h110B
`define BPM_IDX_B1CNT   14'h1110
`define BPM_IDX_B2CNT   14'h1114

// reset values and writable or implemented bits
`define BPM_CTRL_RST    8'h00
`define BPM_CTRL_WMASK  8'h7F
`define BPM_IRQEN_RST   8'h18
`define BPM_STAT_IMPL   8'h18

// field positions
`define BPM_BIT_B1MODE  0
`define BPM_BIT_B2MODE  1
`define BPM_BIT_B1ERR   3
`define BPM_BIT_B2ERR   4

`endif

// File: rtl/bpm_pkg.sv
package bpm_pkg;

	// one byte of the received frame with its position marks from the framer
	typedef struct packed {
		logic       vld;
		logic       sof;
		logic       soh;
		logic       b1;
		logic       b2;
		logic [1:0] slot;
		logic [7:0] data;
	} bpm_rx_byte_t;

	// bus slave states, one-hot
	typedef enum logic [1:0] {
		BPM_IDLE = 2'b01,
		BPM_ACK  = 2'b10
	} bpm_bus_st_t;

	// number of ones in a byte, 0 to 8
	function automatic logic [3:0] bpm_ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

endpackage

// File: rtl/bpm_bip_acc.sv
`timescale 1ns/1ps

// per-lane running BIP-8; the finished value of a frame is kept while the next one runs
module bpm_bip_acc #(
	parameter int LANES = 1
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   restart_i,
	input  wire logic                   en_i,
	input  wire logic [1:0]             lane_i,
	input  wire logic [7:0]             data_i,
	output logic      [LANES-1:0][7:0]  prev_o,
	output logic                        prev_ok_o
);
	logic [LANES-1:0][7:0] acc_r, acc_nxt, prev_r, prev_nxt;
	logic                  ok_r, ok_nxt;

	if (LANES < 1 || LANES > 4) begin : g_bad
		$error("bpm_bip_acc: LANES must be 1 to 4");
	end

	// restart drops the old sum into prev; the starting byte already counts
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		always_comb begin
			acc_nxt[g]  = restart_i ? 8'h00 : acc_r[g];
			prev_nxt[g] = restart_i ? acc_r[g] : prev_r[g];
			if (en_i && lane_i == 2'(g)) begin
				acc_nxt[g] = acc_nxt[g] ^ data_i;
			end
		end
	end

	// no compare until the first frame start after reset was seen
	always_comb begin
		ok_nxt = ok_r | restart_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r  <= '0;
			prev_r <= '0;
			ok_r   <= 1'b0;
		end else begin
			acc_r  <= acc_nxt;
			prev_r <= prev_nxt;
			ok_r   <= ok_nxt;
		end
	end

	assign prev_o    = prev_r;
	assign prev_ok_o = ok_r;

endmodule

// File: rtl/bpm_err_cnt.sv
`timescale 1ns/1ps

// error tally; sticks at all ones rather than wrapping back to a small figure
module bpm_err_cnt #(
	parameter int W = 32
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic [4:0]    add_i,
	output logic      [W-1:0]  cnt_o
);
	logic [W-1:0] cnt_r, cnt_nxt;
	logic [W:0]   sum;

	if (W < 8 || W > 32) begin : g_bad
		$error("bpm_err_cnt: W must be 8 to 32");
	end

	// add with saturation
	always_comb begin
		sum     = {1'b0, cnt_r} + (W+1)'(add_i);
		cnt_nxt = sum[W] ? '1 : sum[W-1:0];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt_o = cnt_r;

endmodule

// File: sim/bpm_frame_src.sv
`timescale 1ns/1ps

// framer-side byte source; parity bytes carry the previous frame's sums xor an error mask
module bpm_frame_src (
	input  wire logic          clk_i,
	output bpm_pkg::bpm_rx_byte_t byte_o
);
	import bpm_pkg::*;

	logic [7:0]      b1_acc;
	logic [2:0][7:0] b2_acc;
	logic [7:0]      b1_prv;
	logic [2:0][7:0] b2_prv;
	int              seq;

	// start idle so the block sees no byte before reset lets go
	initial begin
		byte_o = '0;
		b1_acc = 8'h00;
		b2_acc = '0;
		seq = 0;
	end

	// idle line inverts the value before it, so every second idle in a run repeats the last data
	task automatic idle();
		@(posedge clk_i);
		byte_o.vld <= 1'b0;
		byte_o.data <= ~byte_o.data;
	endtask

	// one byte on the stream, folded into the running sums
	task automatic put(input logic sof, soh, b1, b2, input logic [1:0] sl, input logic [7:0] d);
		@(posedge clk_i);
		byte_o <= '{1'b1, sof, soh, b1, b2, sl, d};
		b1_acc = b1_acc ^ d;
		if (!soh) begin
			b2_acc[sl] = b2_acc[sl] ^ d;
		end
	endtask

	// whole frame; slow inserts a gap in the payload
	task automatic send_frame(input logic [7:0] e1, input logic [2:0][7:0] e2, input bit slow);
		b1_prv = b1_acc;
		b2_prv = b2_acc;
		b1_acc = 8'h00;
		b2_acc = '0;
		seq++;
		put(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'hF6);
		put(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, b1_prv ^ e1);
		for (int i = 0; i < 3; i++) begin
			put(1'b0, 1'b0, 1'b0, 1'b1, 2'(i), b2_prv[i] ^ e2[i]);
		end
		for (int i = 0; i < 12; i++) begin
			if (slow && i == 5) begin
				repeat (3) idle();
			end
			put(1'b0, 1'b0, 1'b0, 1'b0, 2'(i % 3), 8'(seq * 37 + i * 11));
		end
		idle();
	endtask
endmodule

// File: sim/bpm_top_tb_top.sv
`timescale 1ns/1ps
`include "bpm_cfg.svh"

module bpm_top_tb_top;
	import bpm_pkg::*;

	logic         ref_clk_i = 1'b0;
	logic         reset_n_i = 1'b0;
	bpm_rx_byte_t rx_byte;
	logic [15:0]  avs_address_i = 16'h0000;
	logic         avs_read_i = 1'b0;
	logic         avs_write_i = 1'b0;
	logic [31:0]  avs_writedata_i = 32'h0000_0000;
	logic [3:0]   avs_byteenable_i = 4'h0;
	logic         avs_waitrequest_o;
	logic [31:0]  avs_readdata_o;
	logic         int_n_o;
	int           bad_count = 0;
	int           num_checks = 0;
	logic [31:0]  b1_exp = 32'h0;
	logic [31:0]  b2_exp = 32'h0;
	logic [7:0]   mode = 8'h00;

	// 25 MHz
	always #20 ref_clk_i = ~ref_clk_i;

	bpm_top dut (
		.ref_clk_i        (ref_clk_i),
		.reset_n_i        (reset_n_i),
		.rx_byte_i        (rx_byte),
		.avs_address_i    (avs_address_i),
		.avs_read_i       (avs_read_i),
		.avs_write_i      (avs_write_i),
		.avs_writedata_i  (avs_writedata_i),
		.avs_byteenable_i (avs_byteenable_i),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_readdata_o   (avs_readdata_o),
		.int_n_o          (int_n_o)
	);

	bpm_frame_src src (
		.clk_i (ref_clk_i),
		.byte_o(rx_byte)
	);

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one access; held until waitrequest is sampled low, only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
			input logic [3:0] be, output logic [31:0] rd);
		@(posedge ref_clk_i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= {24'h0, wd};
		avs_byteenable_i <= be;
		do begin
			@(posedge ref_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] be);
		logic [31:0] x;
		bus(1'b1, idx, d, be, x);
	endtask

	task automatic rd(input logic [13:0] idx, output logic [31:0] d);
		bus(1'b0, idx, 8'h00, 4'hF, d);
	endtask

	// counter bytes: base holds the top byte and freezes the rest
	task automatic rd_cnt(input logic [13:0] base, output logic [31:0] v);
		logic [31:0] x;
		for (int i = 0; i < 4; i++) begin
			rd(base + 14'(i), x);
			v[31 - 8 * i -: 8] = x[7:0];
		end
	endtask

	task automatic set_mode(input logic [7:0] m);
		mode = m;
		wr(`BPM_IDX_CTRL, m, 4'h1);
	endtask

	// send a frame and keep the expected tallies
	task automatic frame(input logic [7:0] e1, input logic [2:0][7:0] e2, input bit slow);
		src.send_frame(e1, e2, slow);
		if (e1 != 8'h00) begin
			b1_exp += mode[0] ? 32'h1 : 32'($countones(e1));
		end
		if (e2 != '0) begin
			b2_exp += mode[1] ? 32'h1 : 32'($countones(e2));
		end
		repeat (2) @(posedge ref_clk_i);
	endtask

	task automatic t_reset();
		logic [31:0] x;
		rd(`BPM_IDX_CTRL, x);
		chk(x, 32'h00);
		rd(`BPM_IDX_IRQEN, x);
		chk(x, 32'h18);
		frame(8'h00, '0, 1'b0);
		frame(8'h00, '0, 1'b1);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h00);
		rd_cnt(`BPM_IDX_B1CNT, x);
		chk(x, 32'h0);
		rd_cnt(`BPM_IDX_B2CNT, x);
		chk(x, 32'h0);
		chk(int_n_o, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_regs();
		logic [31:0] x;
		wr(`BPM_IDX_CTRL, 8'hFF, 4'h1);
		rd(`BPM_IDX_CTRL, x);
		chk(x, 32'h7F);
		// byte lane 0 disabled, so the write must not land
		wr(`BPM_IDX_CTRL, 8'h00, 4'h0);
		rd(`BPM_IDX_CTRL, x);
		chk(x, 32'h7F);
		rd(14'h1200, x);
		chk(x, 32'h0);
		set_mode(8'h00);
		$display("test regs done");
	endtask

	task automatic t_b1();
		logic [31:0] x;
		frame(8'h81, '0, 1'b0);
		chk(int_n_o, 1'b0);
		frame(8'hFF, '0, 1'b1);
		rd_cnt(`BPM_IDX_B1CNT, x);
		chk(x, b1_exp);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h08);
		repeat (2) @(posedge ref_clk_i);
		chk(int_n_o, 1'b1);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h00);
		set_mode(8'h01);
		frame(8'h0F, '0, 1'b0);
		frame(8'h01, '0, 1'b0);
		frame(8'h00, '0, 1'b1);
		rd_cnt(`BPM_IDX_B1CNT, x);
		chk(x, b1_exp);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h08);
		$display("test section parity done");
	endtask

	task automatic t_b2();
		logic [31:0] x;
		set_mode(8'h00);
		frame(8'h00, {8'hFF, 8'hFF, 8'hFF}, 1'b0);
		frame(8'h00, {8'h00, 8'h03, 8'h00}, 1'b1);
		chk(int_n_o, 1'b0);
		rd_cnt(`BPM_IDX_B2CNT, x);
		chk(x, b2_exp);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h10);
		wr(`BPM_IDX_IRQEN, 8'h00, 4'h1);
		set_mode(8'h02);
		frame(8'h00, {8'h80, 8'h00, 8'h01}, 1'b0);
		chk(int_n_o, 1'b1);
		wr(`BPM_IDX_IRQEN, 8'h18, 4'h1);
		repeat (2) @(posedge ref_clk_i);
		chk(int_n_o, 1'b0);
		wr(`BPM_IDX_STAT, 8'h10, 4'h1);
		repeat (2) @(posedge ref_clk_i);
		chk(int_n_o, 1'b1);
		rd_cnt(`BPM_IDX_B2CNT, x);
		chk(x, b2_exp);
		rd(`BPM_IDX_STAT, x);
		chk(x, 32'h00);
		$display("test line parity done");
	endtask

	// reset for three cycles, then the scenarios in turn
	initial begin
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_reset();
		t_regs();
		t_b1();
		t_b2();
		complete_run();
	end

	// about 360 cycles are needed; a hang ends the run well beyond that
	initial begin
		#(40 * 10000);
		bad_count++;
		complete_run();
	end
endmodule
